// *** common/omf_pkg.sv ***
// ---------------------------------------------------------------
// How it works
// - one-wire-only mode: analog off, readout allowed
// - windowed mode: analog after startup and window expiry
// - enter-command in window moves to command state
// - analog-only: analog at once, refuse single-line readout
// - analog code feeds 13-bit resistor-string converter
// - any failure forces the diagnostic state
// - diagnostic state holds line in low fault band
// - readout during failure returns the error code
// - watchdog flags a stalled controller
// - oscillator monitor flags a stopped oscillator
// - memory integrity failure counts as failure
// - control register parity mismatch counts as failure
// - sensor open or short counts as failure
// - both interfaces read results and configure; no single-line readout in analog-only
// - startup error gives diagnostic state, low band
// - start routine: low band analog, else tri-state
// - clip 15-bit result to output limits
// ---------------------------------------------------------------
package omf_pkg;

   // output modes
   typedef enum logic [1:0] {
      one_wire_only_output      = 2'h0,
      window_then_analog_output = 2'h1,
      analog_with_wire_window   = 2'h2,
      analog_only_output        = 2'h3
   } omf_mode_type;

   typedef enum logic [5:0] {
      ST_CONFIG  = 6'h01,
      ST_ROUTINE = 6'h02,
      ST_WINDOW  = 6'h04,
      normal_run_state  = 6'h08,
      command_state     = 6'h10,
      diagnostic_state  = 6'h20
   } omf_state_type;

   typedef struct packed {
      logic wdg;
      logic osc;
      logic mem;
      logic parity;
      logic open;
      logic short_c;
   } omf_fail_type;

   typedef struct packed {
      logic drive;            // analog buffer active
      logic low_fault_band;   // buffer forced to low fault band
      logic hiz;              // line released
   } omf_line_type;

   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned WIN_TIME_MS  = 500;
   localparam int unsigned WIN_CYC      = WIN_TIME_MS * 1000 * CLK_MHZ;
   localparam int unsigned CFG_TIME_US  = 200;
   localparam int unsigned CFG_CYC      = CFG_TIME_US * CLK_MHZ;
   localparam int unsigned WDG_TIME_US  = 100;
   localparam int unsigned WDG_CYC      = WDG_TIME_US * CLK_MHZ;
   localparam int unsigned OSC_GAP_NS   = 1000;
   localparam int unsigned OSC_CYC      = OSC_GAP_NS * CLK_MHZ / 1000;
   localparam int unsigned CONV_COUNT   = 5;
   localparam int unsigned CNT_W        = 26;
   localparam int unsigned RES_W        = 15;
   localparam int unsigned DAC_W_DEF    = 13;
   localparam int unsigned CTL_W        = 16;
   localparam logic [7:0]  CMD_ENTER    = 8'hA5;  // arbitrary
   localparam logic [15:0] ERR_CODE     = 16'hFFFF;
   localparam logic [1:0]  MODE_RESET   = 2'h3;

endpackage

// *** verilog/omf_fail_mon.sv ***
`timescale 1ns/1ps
module omf_fail_mon import omf_pkg::*; #(
   parameter int unsigned WDG_LIMIT = WDG_CYC,
   parameter int unsigned OSC_LIMIT = OSC_CYC
) (
   input  wire logic               clk_i,        // system clock
   input  wire logic               arst_n_i,     // async reset, active low
   input  wire logic               wdg_kick_i,   // controller alive pulse
   input  wire logic               osc_ref_i,    // oscillator tap, foreign domain
   input  wire logic               mem_fail_i,   // integrity check failed, pulse
   input  wire logic [CTL_W-1:0]   ctl_word_i,   // control register contents
   input  wire logic               ctl_par_i,    // stored even parity bit
   input  wire logic               sns_open_i,   // open-wire comparator pin
   input  wire logic               sns_short_i,  // short comparator pin
   output omf_fail_type            fail_o        // per-cause failure levels
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [2:0] pin_raw;
   logic [2:0] s1_reg, s2_reg, s3_reg, pin_reg;
   assign pin_raw = {osc_ref_i, sns_open_i, sns_short_i};

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
               s1_reg[g]  <= 1'b0;
               s2_reg[g]  <= 1'b0;
               s3_reg[g]  <= 1'b0;
               pin_reg[g] <= 1'b0;
            end else begin
               s1_reg[g] <= pin_raw[g];
               s2_reg[g] <= s1_reg[g];
               s3_reg[g] <= s2_reg[g];
               // change counts only once stages two and three agree
               if (s2_reg[g] == s3_reg[g]) pin_reg[g] <= s3_reg[g];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // watchdog and oscillator counters
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] wdg_reg, osc_reg;
   logic             osc_last_reg;
   omf_fail_type     fail_reg;
   wire              osc_edge   = pin_reg[2] != osc_last_reg;
   wire              wdg_expire = wdg_reg == CNT_W'(WDG_LIMIT - 1);
   wire              osc_expire = osc_reg == CNT_W'(OSC_LIMIT - 1);
   wire              par_bad    = (^ctl_word_i) != ctl_par_i;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wdg_reg      <= '0;
         osc_reg      <= '0;
         osc_last_reg <= 1'b0;
         fail_reg     <= '0;
      end else begin
         wdg_reg      <= (wdg_kick_i || wdg_expire) ? '0 : wdg_reg + 1'b1;
         osc_reg      <= (osc_edge || osc_expire) ? '0 : osc_reg + 1'b1;
         osc_last_reg <= pin_reg[2];
         if (wdg_expire && !wdg_kick_i) fail_reg.wdg <= 1'b1;
         if (osc_expire && !osc_edge)   fail_reg.osc <= 1'b1;
         if (mem_fail_i)                fail_reg.mem <= 1'b1;
         if (par_bad)                   fail_reg.parity <= 1'b1;
         if (pin_reg[1])                fail_reg.open <= 1'b1;
         if (pin_reg[0])                fail_reg.short_c <= 1'b1;
      end
   end
   assign fail_o = fail_reg;

   a_wdg_timeout: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (wdg_expire && !wdg_kick_i) |=> fail_o.wdg)
      else $error("watchdog expiry not flagged");
   a_parity_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      par_bad |=> fail_o.parity)
      else $error("parity mismatch not flagged");
endmodule

// *** verilog/omf_output_ctrl.sv ***
`timescale 1ns/1ps
module omf_output_ctrl import omf_pkg::*; #(
   parameter int unsigned CFG_LIMIT = CFG_CYC,
   parameter int unsigned WIN_LIMIT = WIN_CYC,
   parameter int unsigned WDG_LIMIT = WDG_CYC,
   parameter int unsigned DAC_W     = DAC_W_DEF
) (
   input  wire logic               clk_i,          // 100 MHz clock
   input  wire logic               arst_n_i,       // async reset, active low
   input  wire logic [1:0]         cfg_mode_i,     // stored output mode
   input  wire logic               conv_done_i,    // conversion finished, pulse
   input  wire logic               rx_valid_i,     // decoded link command, pulse
   input  wire logic [7:0]         rx_cmd_i,       // decoded link command code
   input  wire logic               cmd_mode_wr_i,  // write mode in command state, pulse
   input  wire logic [1:0]         cmd_mode_i,     // new mode value
   input  wire logic               cmd_exit_i,     // leave command state, pulse
   input  wire logic [RES_W-1:0]   result_i,       // conditioned result
   input  wire logic [RES_W-1:0]   lim_low_i,      // lower output limit
   input  wire logic [RES_W-1:0]   lim_high_i,     // upper output limit
   input  wire logic               rd_req_i,       // readout request, pulse
   input  wire logic               rd_wire_i,      // 1 single-line link, 0 two-wire
   output logic                    rd_ack_o,       // readout answered, pulse
   output logic                    rd_refused_o,   // readout refused, pulse
   output logic [15:0]             rd_data_o,      // readout word
   input  wire logic               wdg_kick_i,     // controller alive pulse
   input  wire logic               osc_ref_i,      // oscillator tap pin
   input  wire logic               mem_fail_i,     // integrity failure pulse
   input  wire logic [CTL_W-1:0]   ctl_word_i,     // control register contents
   input  wire logic               ctl_par_i,      // control register parity
   input  wire logic               sns_open_i,     // open-wire pin
   input  wire logic               sns_short_i,    // short pin
   output omf_line_type            line_o,         // shared_output_line control
   output logic [DAC_W-1:0]        dac_code_o,     // resistor-string converter code
   output omf_mode_type            mode_o,         // active output mode
   output omf_state_type           state_o,        // working state
   output omf_fail_type            fail_o          // failure causes
);
   // ---------------------------------------------------------------
   // failure supervision
   // ---------------------------------------------------------------
   omf_fail_type fail;
   omf_fail_mon #(
      .WDG_LIMIT (WDG_LIMIT),
      .OSC_LIMIT (OSC_CYC)
   ) u_mon (
      .clk_i       (clk_i),
      .arst_n_i    (arst_n_i),
      .wdg_kick_i  (wdg_kick_i),
      .osc_ref_i   (osc_ref_i),
      .mem_fail_i  (mem_fail_i),
      .ctl_word_i  (ctl_word_i),
      .ctl_par_i   (ctl_par_i),
      .sns_open_i  (sns_open_i),
      .sns_short_i (sns_short_i),
      .fail_o      (fail)
   );
   wire any_fail = |fail;
   assign fail_o = fail;

   // ---------------------------------------------------------------
   // state decode
   // ---------------------------------------------------------------
   omf_state_type    state_reg, state_next;
   omf_mode_type     mode_reg;
   logic [CNT_W-1:0] cnt_reg;
   logic [2:0]       conv_reg;

   wire cfg_end    = cnt_reg == CNT_W'(CFG_LIMIT - 1);
   wire win_end    = cnt_reg == CNT_W'(WIN_LIMIT - 1);
   wire routine_end = conv_done_i && (conv_reg == 3'(CONV_COUNT - 1));
   wire enter_cmd  = rx_valid_i && (rx_cmd_i == CMD_ENTER);
   wire windowed   = (mode_reg == window_then_analog_output) ||
                     (mode_reg == analog_with_wire_window);
   wire analog_md  = (mode_reg == analog_with_wire_window) ||
                     (mode_reg == analog_only_output);

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_CONFIG:  if (cfg_end) state_next = ST_ROUTINE;
         ST_ROUTINE: if (routine_end) state_next = windowed ? ST_WINDOW : normal_run_state;
         ST_WINDOW: begin
            if (enter_cmd) state_next = command_state;
            else if (win_end) state_next = normal_run_state;
         end
         normal_run_state: state_next = normal_run_state;
         command_state:    if (cmd_exit_i) state_next = normal_run_state;
         diagnostic_state: state_next = diagnostic_state;
         default:          state_next = diagnostic_state;
      endcase
      if (any_fail) state_next = diagnostic_state;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= ST_CONFIG;
         mode_reg  <= omf_mode_type'(MODE_RESET);
         cnt_reg   <= '0;
         conv_reg  <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg   <= (state_next != state_reg) ? '0 : cnt_reg + 1'b1;
         if (state_reg != ST_ROUTINE) conv_reg <= '0;
         else if (conv_done_i) conv_reg <= conv_reg + 1'b1;
         if (state_reg == ST_CONFIG && cfg_end)
            mode_reg <= omf_mode_type'(cfg_mode_i);
         else if (state_reg == command_state && cmd_mode_wr_i)
            mode_reg <= omf_mode_type'(cmd_mode_i);
      end
   end
   assign state_o = state_reg;
   assign mode_o  = mode_reg;

   // ---------------------------------------------------------------
   // line control
   // ---------------------------------------------------------------
   // in the window the analog-with-window buffer keeps driving; it is
   // current limited so the master can overdrive it while sending
   wire in_diag  = state_reg == diagnostic_state;
   wire drive_ok = (state_reg == normal_run_state && mode_reg != one_wire_only_output) ||
                   (state_reg == ST_WINDOW && mode_reg == analog_with_wire_window);
   wire band_low = in_diag || state_reg == ST_CONFIG ||
                   (state_reg == ST_ROUTINE && analog_md);
   assign line_o.drive          = drive_ok;
   assign line_o.low_fault_band = band_low;
   assign line_o.hiz            = !drive_ok && !band_low;

   // ---------------------------------------------------------------
   // analog code and readout
   // ---------------------------------------------------------------
   logic [RES_W-1:0] clip_reg;
   logic             ack_reg, ref_reg;
   logic [15:0]      rd_reg;
   wire [RES_W-1:0]  clipped = (result_i < lim_low_i)  ? lim_low_i :
                               (result_i > lim_high_i) ? lim_high_i : result_i;
   wire rd_state   = state_reg == normal_run_state || state_reg == ST_WINDOW ||
                     state_reg == command_state || in_diag;
   wire rd_refuse  = !rd_state || (rd_wire_i && mode_reg == analog_only_output);

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         clip_reg <= '0;
         ack_reg  <= 1'b0;
         ref_reg  <= 1'b0;
         rd_reg   <= '0;
      end else begin
         clip_reg <= clipped;
         ack_reg  <= rd_req_i && !rd_refuse;
         ref_reg  <= rd_req_i && rd_refuse;
         if (rd_req_i && !rd_refuse)
            rd_reg <= in_diag ? ERR_CODE : {1'b0, result_i};
      end
   end
   assign dac_code_o   = clip_reg[RES_W-1 -: DAC_W];
   assign rd_ack_o     = ack_reg;
   assign rd_refused_o = ref_reg;
   assign rd_data_o    = rd_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_win_quiet;
      state_reg == ST_WINDOW && win_end && !enter_cmd && !any_fail;
   endsequence
   sequence s_read_in_diag;
      rd_req_i && in_diag && !rd_refuse;
   endsequence

   a_fail_to_diag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      any_fail |=> state_reg == diagnostic_state)
      else $error("failure did not force diagnostic state");
   a_diag_sticky: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      in_diag |=> in_diag [*8])
      else $error("diagnostic state left before reset");
   a_diag_band: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      in_diag |-> line_o.low_fault_band && !line_o.drive)
      else $error("diagnostic state without low fault band");
   a_win_expiry: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_win_quiet |=> state_reg == normal_run_state ##0 (line_o.drive == 1'b1))
      else $error("window expiry did not start analog output");
   a_cmd_entry: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_reg == ST_WINDOW && enter_cmd && !any_fail) |=> state_reg == command_state)
      else $error("enter command ignored in window");
   a_wire_only: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      mode_reg == one_wire_only_output |-> !line_o.drive)
      else $error("analog driven in one-wire-only mode");
   a_refuse_read: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (rd_req_i && rd_wire_i && mode_reg == analog_only_output) |=> rd_refused_o && !rd_ack_o)
      else $error("single-line readout served in analog-only mode");
   a_err_code: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_read_in_diag |=> rd_ack_o && rd_data_o == ERR_CODE)
      else $error("error code missing on readout");
   a_clip_range: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (lim_low_i <= lim_high_i && $stable(lim_low_i) && $stable(lim_high_i)) |=>
      clip_reg >= $past(lim_low_i) && clip_reg <= $past(lim_high_i))
      else $error("analog code outside output limits");
   a_routine_line: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      state_reg == ST_ROUTINE |-> (analog_md ? line_o.low_fault_band : line_o.hiz))
      else $error("wrong line state in start routine");

   sequence s_analog_start;
      state_reg == ST_ROUTINE && routine_end && mode_reg == analog_only_output && !any_fail;
   endsequence
   a_analog_start: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_analog_start |=> state_reg == normal_run_state && line_o.drive)
      else $error("analog-only output not started after start routine");
   a_window_open: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_reg == ST_ROUTINE && routine_end && windowed && !any_fail) |=> state_reg == ST_WINDOW)
      else $error("startup window not opened");
   a_line_onehot: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      $onehot({line_o.drive, line_o.low_fault_band, line_o.hiz}))
      else $error("line control not one-hot");
   a_config_band: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      state_reg == ST_CONFIG |-> line_o.low_fault_band)
      else $error("line not in low fault band during configuration");
   a_mode_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (state_reg != ST_CONFIG && state_reg != command_state) |=> $stable(mode_reg))
      else $error("output mode changed outside configuration and command state");
   a_read_ack: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (rd_req_i && !rd_refuse) |=> rd_ack_o && !rd_refused_o)
      else $error("served readout not acknowledged");
   a_read_startup: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (rd_req_i && (state_reg == ST_CONFIG || state_reg == ST_ROUTINE)) |=> rd_refused_o)
      else $error("readout served during startup");
   a_read_data: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (rd_req_i && !rd_refuse && !in_diag) |=> rd_data_o == {1'b0, $past(result_i)})
      else $error("readout word differs from conditioned result");
endmodule

// *** sim/omf_link_master.sv ***
`timescale 1ns/1ps
module omf_link_master import omf_pkg::*; (
   input  wire logic        clk_i,         // system clock
   input  wire logic        rd_ack_i,      // readout answered
   input  wire logic        rd_refused_i,  // readout refused
   input  wire logic [15:0] rd_data_i,     // readout word
   output logic             rx_valid_o,    // command strobe
   output logic [7:0]       rx_cmd_o,      // command code
   output logic             rd_req_o,      // readout request
   output logic             rd_wire_o      // 1 single-line link, 0 two-wire
);
   initial begin
      rx_valid_o = 1'b0;
      rx_cmd_o   = 8'h00;
      rd_req_o   = 1'b0;
      rd_wire_o  = 1'b0;
   end
   // ------------------------------------------------------------
   // master transfers, launched on the falling edge
   // ------------------------------------------------------------
   // the buffer is current limited, so the master simply wins the line here
   task automatic send_cmd(input logic [7:0] code);
      @(negedge clk_i);
      rx_cmd_o   = code;
      rx_valid_o = 1'b1;
      @(negedge clk_i);
      rx_valid_o = 1'b0;
      rx_cmd_o   = ~code;
   endtask
   // released selects show the inverse so a stale value never looks valid
   task automatic read_word(input logic sel, output logic ack, output logic refd, output logic [15:0] data);
      @(negedge clk_i);
      rd_wire_o = sel;
      rd_req_o  = 1'b1;
      @(negedge clk_i);
      rd_req_o  = 1'b0;
      // the answer stands for one cycle only, so it is taken here
      ack       = rd_ack_i;
      refd      = rd_refused_i;
      data      = rd_data_i;
      rd_wire_o = ~sel;
   endtask
endmodule

// *** sim/test_output_mode_failsafe_control.sv ***
`timescale 1ns/1ps
module test_output_mode_failsafe_control import omf_pkg::*;;
   localparam int unsigned CFG_L = 20;
   localparam int unsigned WIN_L = 200;
   localparam int unsigned WDG_L = 50;
   logic clk_i = 1'b0, arst_n_i = 1'b0, conv_done_i = 1'b0, rx_valid_i, cmd_mode_wr_i = 1'b0, cmd_exit_i = 1'b0;
   logic rd_req_i, rd_wire_i, wdg_kick_i = 1'b0, osc_ref_i = 1'b0, mem_fail_i = 1'b0, ctl_par_i = 1'b0;
   logic sns_open_i = 1'b0, sns_short_i = 1'b0, kick_en = 1'b1, osc_en = 1'b1, ack, refd;
   logic [1:0] cfg_mode_i = 2'h3, cmd_mode_i = 2'h0;
   logic [7:0] rx_cmd_i;
   logic [14:0] result_i = 15'h0, lim_low_i = 15'h0, lim_high_i = 15'h7FFF;
   logic [15:0] ctl_word_i = 16'h0, rd_data_o, rdat;
   logic [31:0] seed = 32'h2578, cyc = 32'h0;
   logic rd_ack_o, rd_refused_o;
   logic [12:0] dac_code_o;
   omf_line_type line_o;
   omf_mode_type mode_o;
   omf_state_type state_o;
   omf_fail_type fail_o;
   int failures = 0, checked = 0;

   omf_output_ctrl #(.CFG_LIMIT(CFG_L), .WIN_LIMIT(WIN_L), .WDG_LIMIT(WDG_L)) dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .cfg_mode_i(cfg_mode_i), .conv_done_i(conv_done_i),
      .rx_valid_i(rx_valid_i), .rx_cmd_i(rx_cmd_i), .cmd_mode_wr_i(cmd_mode_wr_i), .cmd_mode_i(cmd_mode_i),
      .cmd_exit_i(cmd_exit_i), .result_i(result_i), .lim_low_i(lim_low_i), .lim_high_i(lim_high_i),
      .rd_req_i(rd_req_i), .rd_wire_i(rd_wire_i), .rd_ack_o(rd_ack_o), .rd_refused_o(rd_refused_o),
      .rd_data_o(rd_data_o), .wdg_kick_i(wdg_kick_i), .osc_ref_i(osc_ref_i), .mem_fail_i(mem_fail_i),
      .ctl_word_i(ctl_word_i), .ctl_par_i(ctl_par_i), .sns_open_i(sns_open_i), .sns_short_i(sns_short_i),
      .line_o(line_o), .dac_code_o(dac_code_o), .mode_o(mode_o), .state_o(state_o), .fail_o(fail_o));
   omf_link_master link (
      .clk_i(clk_i), .rd_ack_i(rd_ack_o), .rd_refused_i(rd_refused_o), .rd_data_i(rd_data_o),
      .rx_valid_o(rx_valid_i), .rx_cmd_o(rx_cmd_i), .rd_req_o(rd_req_i), .rd_wire_o(rd_wire_i));

   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // ------------------------------------------------------------
   // free-running environment: conversions, kicks, oscillator tap
   // ------------------------------------------------------------
   always @(negedge clk_i) begin
      cyc         <= cyc + 32'h1;
      conv_done_i <= (cyc[2:0] == 3'h0);
      wdg_kick_i  <= kick_en && (cyc[3:0] == 4'h0);
      // slower than every cycle, else sync stages two and three never agree
      if (osc_en && cyc[1:0] == 2'h0)
         osc_ref_i <= ~osc_ref_i;
      if (cyc == 32'd20000) begin
         failures++;
         final_report();
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // line code is {drive, low band, released}
   function automatic logic [2:0] exp_line(input logic [5:0] st, input logic [1:0] md);
      case (st)
         6'h02: exp_line = md[1] ? 3'h2 : 3'h1;
         6'h04: exp_line = (md == 2'h2) ? 3'h4 : 3'h1;
         6'h08: exp_line = (md == 2'h0) ? 3'h1 : 3'h4;
         6'h10: exp_line = 3'h1;
         default: exp_line = 3'h2;
      endcase
   endfunction
   function automatic logic [12:0] exp_dac(input logic [14:0] r, input logic [14:0] lo, input logic [14:0] hi);
      logic [14:0] v;
      v = (r < lo) ? lo : ((r > hi) ? hi : r);
      return v[14:2];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wait_state(input logic [5:0] st, input int unsigned lim);
      int unsigned n;
      n = 0;
      while (state_o !== st && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      chk(32'(state_o), 32'(st));
   endtask
   task automatic do_reset(input logic [1:0] md);
      @(negedge clk_i);
      arst_n_i    = 1'b0;
      cfg_mode_i  = md;
      kick_en     = 1'b1;
      osc_en      = 1'b1;
      sns_open_i  = 1'b0;
      sns_short_i = 1'b0;
      result_i    = 15'(rnd());
      ctl_word_i  = 16'(rnd());
      ctl_par_i   = ^ctl_word_i;
      repeat (16) @(negedge clk_i);
      arst_n_i = 1'b1;
   endtask
   task automatic inject(input int c, input logic on);
      @(negedge clk_i);
      case (c)
         0: kick_en = ~on;
         1: osc_en = ~on;
         2: mem_fail_i = on;
         3: ctl_par_i = (^ctl_word_i) ^ on;
         4: sns_open_i = on;
         default: sns_short_i = on;
      endcase
      @(negedge clk_i);
      mem_fail_i = 1'b0;
   endtask
   task automatic pulse_cmd(input logic wr);
      @(negedge clk_i);
      cmd_mode_wr_i = wr;
      cmd_exit_i    = ~wr;
      @(negedge clk_i);
      cmd_mode_wr_i = 1'b0;
      cmd_exit_i    = 1'b0;
      @(negedge clk_i);
   endtask
   task automatic reach_run(input logic [1:0] md);
      do_reset(md);
      chk(32'(line_o), 32'h2);
      link.read_word(1'b0, ack, refd, rdat);
      chk(32'(refd), 32'h1);
      wait_state(6'h02, CFG_L + 4);
      chk(32'(mode_o), 32'(md));
      chk(32'(line_o), 32'(exp_line(6'h02, md)));
      wait_state((md == 2'h1 || md == 2'h2) ? 6'h04 : 6'h08, 80);
      chk(32'(line_o), 32'(exp_line(state_o, md)));
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      int i;
      logic [14:0] a;
      logic [14:0] b;
      for (i = 0; i < 4; i++) begin
         reach_run(2'(i));
         link.read_word(1'b1, ack, refd, rdat);
         chk(32'(refd), 32'(i == 3));
         link.read_word(1'b0, ack, refd, rdat);
         chk(32'({ack, rdat}), 32'({2'h2, result_i}));
         if (i == 1) begin
            wait_state(6'h08, WIN_L + 8);
            chk(32'(line_o), 32'h4);
         end
         if (i == 2) begin
            link.send_cmd(8'h5A);
            chk(32'(state_o), 32'h04);
            link.send_cmd(CMD_ENTER);
            chk(32'(state_o), 32'h10);
            pulse_cmd(1'b1);
            pulse_cmd(1'b0);
            chk(32'({state_o, mode_o, line_o}), 32'({6'h08, 2'h0, 3'h1}));
         end
      end
      reach_run(2'h3);
      for (i = 0; i < 24; i++) begin
         a = 15'(rnd());
         b = 15'(rnd());
         @(negedge clk_i);
         result_i   = (i == 0) ? 15'h7FFF : ((i == 1) ? 15'h0 : 15'(rnd()));
         lim_low_i  = (a < b) ? a : b;
         lim_high_i = (i == 2) ? lim_low_i : ((a < b) ? b : a);
         repeat (2) @(negedge clk_i);
         chk(32'(dac_code_o), 32'(exp_dac(result_i, lim_low_i, lim_high_i)));
      end
      for (i = 0; i < 6; i++) begin
         reach_run(2'h3);
         inject(i, 1'b1);
         wait_state(6'h20, 200);
         chk(32'(fail_o), 32'h20 >> i);
         chk(32'(line_o), 32'h2);
         link.read_word(1'b0, ack, refd, rdat);
         chk(32'(rdat), 32'(ERR_CODE));
         inject(i, 1'b0);
         repeat (30) @(negedge clk_i);
         chk(32'(state_o), 32'h20);
      end
      do_reset(2'h1);
      inject(3, 1'b1);
      wait_state(6'h20, 20);
      chk(32'(line_o), 32'h2);
      final_report();
   end
endmodule
